// File: logic/seil_event_irq.sv
`timescale 1ns/1ps
module seil_event_irq
  import seil_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // command port from the serial front end (link domain)
  input wire logic cmd_toggle_i,
  input wire logic [seil_pkg::CMD_W-1:0] cmd_code_i,
  // register port from the serial front end (link domain)
  input wire logic reg_wr_toggle_i,
  input wire logic [seil_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [seil_pkg::DATA_W-1:0] reg_wdata_i,
  output logic [seil_pkg::DATA_W-1:0] reg_rdata_o,
  // conversion engine status (same clock)
  input wire logic asleep_i,
  input wire logic powerup_busy_i,
  input wire logic convert_busy_i,
  input wire logic cmd_busy_i,
  input wire logic temp_done_i,
  input wire logic temp_outside_i,
  input wire logic temp_above_i,
  input wire logic temp_cross_i,
  input wire logic temp_rise_i,
  input wire logic press_done_i,
  input wire logic press_outside_i,
  input wire logic press_above_i,
  input wire logic press_cross_i,
  input wire logic press_rise_i,
  input wire logic threshold_error_flag_i,
  // outputs
  output logic device_ready_flag_o,
  output logic compensation_enable_o,
  output logic press_or_alt_select_o,
  output logic primary_irq_pin_o,
  output logic secondary_irq_pin_o
);
  import seil_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] cmd_code;
    logic [CMD_W-1:0] cmd_meta;
    logic [CMD_W-1:0] cmd_sync;
    logic [DATA_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] wdata_meta;
    logic [DATA_W-1:0] wdata_sync;
    logic [DATA_W-1:0] rd_addr_meta;
    logic [DATA_W-1:0] rd_addr;
    logic [NUM_EV-1:0] int_enable;
    logic [NUM_EV-1:0] int_route;
    logic press_or_alt_select;
    logic compensation_enable;
    logic temp_done_event;
    logic press_done_event;
    logic temp_cross_event;
    logic press_cross_event;
    logic temp_outside_event;
    logic press_outside_event;
    logic temp_window_side;
    logic press_window_side;
    logic temp_cross_sense;
    logic press_cross_sense;
    logic device_ready_flag;
    logic threshold_error_flag_meta;
    logic threshold_error_flag;
    logic primary_irq;
    logic secondary_irq;
    logic [DATA_W-1:0] rdata;
  } seil_state_t;

  seil_state_t st;
  seil_state_t next_st;
  logic cmd_pulse;
  logic wr_pulse;
  logic [NUM_EV-1:0] active_irq;
  logic [DATA_W-1:0] source_view;
  logic [DATA_W-1:0] dir_view;

  // which done flags a recognised command clears: bit0 temperature, bit1 pressure
  function automatic logic [1:0] clear_mask(input logic [CMD_W-1:0] code);
    logic [1:0] m;
    m = 2'h0;
    unique case (code)
      SEIL_CMD_CONVERT, SEIL_CMD_READ_PRESS_TEMP_CMD, SEIL_CMD_READ_ALT_TEMP_CMD: m = 2'h3;
      SEIL_CMD_READ_P, SEIL_CMD_READ_A: m = 2'h2;
      SEIL_CMD_READ_T: m = 2'h1;
      default: m = 2'h0;
    endcase
    return m;
  endfunction

  seil_sync_pulse u_cmd_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .toggle_i(cmd_toggle_i),
    .pulse_o(cmd_pulse)
  );

  seil_sync_pulse u_wr_sync (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .toggle_i(reg_wr_toggle_i),
    .pulse_o(wr_pulse)
  );

  // pin-level interrupts: crossing and window only ride on their done flag
  always_comb begin
    active_irq = '0;
    active_irq[EV_TEMP_DONE] = st.temp_done_event;
    active_irq[EV_PRESS_DONE] = st.press_done_event;
    active_irq[EV_TEMP_CROSS] = st.temp_cross_event & st.temp_done_event;
    active_irq[EV_PRESS_CROSS] = st.press_cross_event & st.press_done_event;
    active_irq[EV_TEMP_OUT] = st.temp_outside_event & st.temp_done_event;
    active_irq[EV_PRESS_OUT] = st.press_outside_event & st.press_done_event;
  end

  always_comb begin
    source_view = REG_RESET;
    source_view[EV_TEMP_DONE] = st.temp_done_event;
    source_view[EV_PRESS_DONE] = st.press_done_event;
    source_view[EV_TEMP_CROSS] = st.temp_cross_event;
    source_view[EV_PRESS_CROSS] = st.press_cross_event;
    source_view[EV_TEMP_OUT] = st.temp_outside_event;
    source_view[EV_PRESS_OUT] = st.press_outside_event;
    source_view[SRC_DEV_READY] = st.device_ready_flag;
    source_view[SRC_TH_ERROR] = st.threshold_error_flag;
    dir_view = REG_RESET;
    dir_view[DIR_TEMP_WIN] = st.temp_window_side;
    dir_view[DIR_PRESS_WIN] = st.press_window_side;
    dir_view[DIR_TEMP_CROSS] = st.temp_cross_sense;
    dir_view[DIR_PRESS_CROSS] = st.press_cross_sense;
  end

  always_comb begin
    logic [1:0] clr;
    logic soft_rst;
    clr = 2'h0;
    soft_rst = 1'b0;
    next_st = st;

    // link-domain words pass two flops; they settle long before their toggle is seen
    next_st.cmd_meta = cmd_code_i;
    next_st.cmd_sync = st.cmd_meta;
    next_st.wdata_meta = reg_wdata_i;
    next_st.wdata_sync = st.wdata_meta;
    if (cmd_pulse) begin
      next_st.cmd_code = DATA_W'(st.cmd_sync);
    end
    if (wr_pulse) begin
      next_st.wr_addr = st.rd_addr;
      next_st.wr_data = st.wdata_sync;
    end
    next_st.rd_addr_meta = DATA_W'(reg_addr_i);
    next_st.rd_addr = st.rd_addr_meta;
    next_st.threshold_error_flag_meta = threshold_error_flag_i;
    next_st.threshold_error_flag = st.threshold_error_flag_meta;

    // the command word is captured on its pulse, so act on the captured copy one cycle later
    if (st.cmd_code != DATA_W'(SEIL_CMD_NONE)) begin
      clr = clear_mask(st.cmd_code[CMD_W-1:0]);
      soft_rst = (st.cmd_code[CMD_W-1:0] == SEIL_CMD_SOFT_RST);
      next_st.cmd_code = DATA_W'(SEIL_CMD_NONE);
    end

    // register writes
    if (st.wr_addr != {DATA_W{1'b1}}) begin
      unique case (st.wr_addr[ADDR_W-1:0])
        ADDR_INT_ENABLE: next_st.int_enable = st.wr_data[NUM_EV-1:0];
        ADDR_INT_ROUTE: begin
          next_st.int_route = st.wr_data[NUM_EV-1:0];
          next_st.press_or_alt_select = st.wr_data[ROUTE_MODE_BIT];
        end
        ADDR_COMPENSATION: next_st.compensation_enable = st.wr_data[COMP_EN_BIT];
        default: next_st.int_route = st.int_route;
      endcase
      next_st.wr_addr = {DATA_W{1'b1}};
    end

    // clears first, so a completion in the same cycle wins
    if (clr[0]) begin
      next_st.temp_done_event = 1'b0;
    end
    if (clr[1]) begin
      next_st.press_done_event = 1'b0;
    end
    if (soft_rst) begin
      next_st.temp_done_event = 1'b0;
      next_st.press_done_event = 1'b0;
      next_st.temp_cross_event = 1'b0;
      next_st.press_cross_event = 1'b0;
      next_st.temp_outside_event = 1'b0;
      next_st.press_outside_event = 1'b0;
      next_st.temp_window_side = 1'b0;
      next_st.press_window_side = 1'b0;
      next_st.temp_cross_sense = 1'b0;
      next_st.press_cross_sense = 1'b0;
      next_st.int_enable = EV_RESET;
      next_st.int_route = EV_RESET;
      next_st.press_or_alt_select = 1'b0;
      next_st.compensation_enable = 1'b0;
    end

    // temperature completion: done flag held until a clearing command, crossing and window flags rewritten
    if (temp_done_i) begin
      next_st.temp_done_event = st.int_enable[EV_TEMP_DONE] | next_st.temp_done_event;
      next_st.temp_cross_event = temp_cross_i & st.int_enable[EV_TEMP_CROSS]
                                 & st.int_enable[EV_TEMP_DONE];
      next_st.temp_outside_event = temp_outside_i & st.int_enable[EV_TEMP_OUT]
                                   & st.int_enable[EV_TEMP_DONE];
      if (temp_outside_i) begin
        next_st.temp_window_side = temp_above_i;
      end
      if (temp_cross_i) begin
        next_st.temp_cross_sense = temp_rise_i;
      end
    end

    // pressure (or altitude) completion
    if (press_done_i) begin
      next_st.press_done_event = st.int_enable[EV_PRESS_DONE] | next_st.press_done_event;
      next_st.press_cross_event = press_cross_i & st.int_enable[EV_PRESS_CROSS]
                                  & st.int_enable[EV_PRESS_DONE];
      next_st.press_outside_event = press_outside_i & st.int_enable[EV_PRESS_OUT]
                                    & st.int_enable[EV_PRESS_DONE];
      if (press_outside_i) begin
        next_st.press_window_side = press_above_i;
      end
      if (press_cross_i) begin
        next_st.press_cross_sense = press_rise_i;
      end
    end

    next_st.device_ready_flag = asleep_i & ~powerup_busy_i & ~convert_busy_i
                                & ~cmd_busy_i;

    // primary pin carries every active event, secondary only routed ones
    next_st.primary_irq = |active_irq;
    next_st.secondary_irq = |(active_irq & st.int_route);

    unique case (st.rd_addr[ADDR_W-1:0])
      ADDR_INT_ENABLE: next_st.rdata = DATA_W'(st.int_enable);
      ADDR_INT_ROUTE: next_st.rdata = {1'b0, st.press_or_alt_select, st.int_route};
      ADDR_EVENT_SOURCE: next_st.rdata = source_view;
      ADDR_EVENT_DIRECTION: next_st.rdata = dir_view;
      ADDR_COMPENSATION: next_st.rdata = DATA_W'(st.compensation_enable);
      default: next_st.rdata = REG_RESET;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
      st.cmd_code <= DATA_W'(SEIL_CMD_NONE);
      st.wr_addr <= {DATA_W{1'b1}};
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_o = st.rdata;
  assign device_ready_flag_o = st.device_ready_flag;
  assign compensation_enable_o = st.compensation_enable;
  assign press_or_alt_select_o = st.press_or_alt_select;
  assign primary_irq_pin_o = st.primary_irq;
  assign secondary_irq_pin_o = st.secondary_irq;
endmodule

// File: logic/seil_pkg.sv
// How it works
// - ready flag high only when asleep and no power-up, conversion or command runs
// - enabled event with routing bit 0 sets its flag but stays off secondary pin
// - window side bit is 1 when value lies above window, 0 below
// - crossing sense bit is 1 when value rose across middle threshold, 0 when fell
// - crossing and window interrupts only while matching done interrupt enabled and set
// - threshold error, ready and four direction bits never drive a pin
// - temperature interrupts rise when temperature conversion finishes
// - pressure interrupts rise when pressure conversion finishes
// - convert and combined read commands clear both done interrupts
// - clearing done drops its window and crossing interrupts; register bits stay
// - pressure-only and altitude-only reads clear only pressure done
// - temperature-only read clears only temperature done
// - soft reset clears every interrupt and related status bits
// - clearing happens when a valid command is recognised
// - compensation enable 1 makes the datapath return compensated results
// - compensation enable 0 makes the datapath return raw results
// - interrupts are active high; done stays until cleared, crossing and window until cleared or next completion
// - enable bit 0 disables its interrupt, 1 enables it
// - mode bit selects pressure (0) or altitude (1) for pressure events
package seil_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_EV = 6;
  localparam int unsigned CMD_W = 4;

  // register indices on the register port
  localparam logic [ADDR_W-1:0] ADDR_INT_ENABLE = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_INT_ROUTE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_SOURCE = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_EVENT_DIRECTION = 4'h3;
  localparam logic [ADDR_W-1:0] ADDR_COMPENSATION = 4'h4;

  // event bit positions, shared by enable, route and source registers
  localparam int unsigned EV_TEMP_DONE = 0;
  localparam int unsigned EV_PRESS_DONE = 1;
  localparam int unsigned EV_TEMP_CROSS = 2;
  localparam int unsigned EV_PRESS_CROSS = 3;
  localparam int unsigned EV_TEMP_OUT = 4;
  localparam int unsigned EV_PRESS_OUT = 5;
  localparam int unsigned SRC_DEV_READY = 6;
  localparam int unsigned SRC_TH_ERROR = 7;
  localparam int unsigned ROUTE_MODE_BIT = 6;

  // direction register bits
  localparam int unsigned DIR_TEMP_WIN = 0;
  localparam int unsigned DIR_PRESS_WIN = 1;
  localparam int unsigned DIR_TEMP_CROSS = 2;
  localparam int unsigned DIR_PRESS_CROSS = 3;

  localparam int unsigned COMP_EN_BIT = 0;

  localparam logic [NUM_EV-1:0] EV_RESET = 6'h00;
  localparam logic [DATA_W-1:0] REG_RESET = 8'h00;

  // altitude settle wait before an altitude read command, host side
  localparam int unsigned ALT_SETTLE_NS = 5000;
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned ALT_SETTLE_CYC = (ALT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [CMD_W-1:0] {
    SEIL_CMD_NONE = 4'h0,
    SEIL_CMD_CONVERT = 4'h1,
    SEIL_CMD_READ_PRESS_TEMP_CMD = 4'h2,
    SEIL_CMD_READ_ALT_TEMP_CMD = 4'h3,
    SEIL_CMD_READ_P = 4'h4,
    SEIL_CMD_READ_A = 4'h5,
    SEIL_CMD_READ_T = 4'h6,
    SEIL_CMD_SOFT_RST = 4'h7
  } seil_cmd_t;

endpackage

// File: logic/seil_sync_pulse.sv
`timescale 1ns/1ps
// two-flop synchroniser for a toggle from the link domain, one pulse per toggle
module seil_sync_pulse (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic toggle_i,
  output logic pulse_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
  } seil_sync_t;

  seil_sync_t st;
  seil_sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.meta = toggle_i;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse_o = st.sync ^ st.prev;
endmodule

// File: dv/seil_event_irq_props.sv
`timescale 1ns/1ps
module seil_event_irq_props
  import seil_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic cmd_toggle_i,
  input wire logic [seil_pkg::CMD_W-1:0] cmd_code_i,
  input wire logic reg_wr_toggle_i,
  input wire logic asleep_i,
  input wire logic powerup_busy_i,
  input wire logic convert_busy_i,
  input wire logic cmd_busy_i,
  input wire logic temp_done_i,
  input wire logic press_done_i,
  input wire logic device_ready_flag_o,
  input wire logic compensation_enable_o,
  input wire logic press_or_alt_select_o,
  input wire logic primary_irq_pin_o,
  input wire logic secondary_irq_pin_o
);
  logic idle;
  assign idle = asleep_i && !powerup_busy_i && !convert_busy_i && !cmd_busy_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_ready;
    !$past(sys_rst_i) |-> device_ready_flag_o == $past(idle);
  endproperty
  a_ready: assert property (p_ready) else $error("ready flag wrong");
  property p_reset;
    $fell(sys_rst_i) |-> !primary_irq_pin_o && !secondary_irq_pin_o && !device_ready_flag_o;
  endproperty
  a_reset: assert property (p_reset) else $error("output high after reset");
  property p_sec;
    secondary_irq_pin_o |-> primary_irq_pin_o;
  endproperty
  a_sec: assert property (p_sec) else $error("secondary without primary");
  property p_rise;
    $rose(primary_irq_pin_o) |-> $past(temp_done_i, 2) || $past(press_done_i, 2);
  endproperty
  a_rise: assert property (p_rise) else $error("pin rose without done");
  property p_srise;
    $rose(secondary_irq_pin_o) |-> $past(temp_done_i, 2) || $past(press_done_i, 2)
      || ($past(reg_wr_toggle_i, 1) != $past(reg_wr_toggle_i, 9));
  endproperty
  a_srise: assert property (p_srise) else $error("secondary rose without cause");
  property p_fall;
    $fell(primary_irq_pin_o) |-> ($past(cmd_toggle_i, 2) != $past(cmd_toggle_i, 9))
      || ($past(reg_wr_toggle_i, 2) != $past(reg_wr_toggle_i, 9));
  endproperty
  a_fall: assert property (p_fall) else $error("pin fell without command");
  property p_clear;
    (cmd_toggle_i != $past(cmd_toggle_i)) && (cmd_code_i inside {SEIL_CMD_CONVERT,
      SEIL_CMD_READ_PRESS_TEMP_CMD, SEIL_CMD_READ_ALT_TEMP_CMD, SEIL_CMD_SOFT_RST})
      ##1 (!temp_done_i && !press_done_i)[*8] |-> !primary_irq_pin_o;
  endproperty
  a_clear: assert property (p_clear) else $error("pin not cleared");
  property p_cfg;
    $changed({compensation_enable_o, press_or_alt_select_o})
      |-> ($past(reg_wr_toggle_i, 1) != $past(reg_wr_toggle_i, 9))
      || ($past(cmd_toggle_i, 1) != $past(cmd_toggle_i, 9));
  endproperty
  a_cfg: assert property (p_cfg) else $error("config moved by itself");
endmodule

bind seil_event_irq seil_event_irq_props u_props (.clk_i, .sys_rst_i, .cmd_toggle_i,
  .cmd_code_i, .reg_wr_toggle_i, .asleep_i, .powerup_busy_i, .convert_busy_i, .cmd_busy_i,
  .temp_done_i, .press_done_i, .device_ready_flag_o, .compensation_enable_o,
  .press_or_alt_select_o, .primary_irq_pin_o, .secondary_irq_pin_o);

// File: dv/seil_host_model.sv
`timescale 1ns/1ps
module seil_host_model
  import seil_pkg::*;
(
  input wire logic clk_i,
  input wire logic ready_i,
  input wire logic [seil_pkg::DATA_W-1:0] rdata_i,
  output logic cmd_toggle_o,
  output logic [seil_pkg::CMD_W-1:0] cmd_code_o,
  output logic wr_toggle_o,
  output logic [seil_pkg::ADDR_W-1:0] addr_o,
  output logic [seil_pkg::DATA_W-1:0] wdata_o
);
  logic lclk = 1'b0;
  initial begin
    cmd_toggle_o = 1'b0;
    wr_toggle_o = 1'b0;
    cmd_code_o = 4'h0;
    addr_o = 4'h0;
    wdata_o = 8'h00;
  end
  task automatic wait_ready();
    for (int i = 0; i < 200 && ready_i !== 1'b1; i++) @(negedge clk_i);
  endtask
  // link clock runs only inside a frame, off phase with the system clock
  task automatic frame(input logic is_cmd);
    wait_ready();
    #37;
    repeat (2) begin
      #400 lclk = 1'b1;
      #400 lclk = 1'b0;
    end
    // the toggle itself moves on a falling edge of the system clock
    @(negedge clk_i);
    if (is_cmd) cmd_toggle_o = ~cmd_toggle_o;
    else wr_toggle_o = ~wr_toggle_o;
    repeat (10) @(negedge clk_i);
  endtask
  task automatic cmd(input logic [3:0] c);
    if (c == SEIL_CMD_READ_A || c == SEIL_CMD_READ_ALT_TEMP_CMD) repeat (ALT_SETTLE_CYC) @(negedge clk_i);
    @(negedge clk_i);
    cmd_code_o = c;
    frame(1'b1);
    cmd_code_o = ~c;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    frame(1'b0);
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    wait_ready();
    @(negedge clk_i);
    addr_o = a;
    repeat (4) @(negedge clk_i);
    d = rdata_i;
  endtask
endmodule

// File: dv/seil_event_irq_tb.sv
`timescale 1ns/1ps
module seil_event_irq_tb;
  import seil_pkg::*;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] st = 4'h8;
  logic temp_done_i = 1'b0;
  logic press_done_i = 1'b0;
  logic threshold_error_flag_i = 1'b0;
  logic [3:0] q = 4'h0;
  logic cmd_toggle_i, reg_wr_toggle_i, device_ready_flag_o, compensation_enable_o;
  logic press_or_alt_select_o, primary_irq_pin_o, secondary_irq_pin_o;
  logic [3:0] cmd_code_i, reg_addr_i;
  logic [7:0] reg_wdata_i, reg_rdata_o, v;
  logic [3:0] cds [8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h0, 4'h8};
  logic [1:0] rem [8] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3};
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  always #50 clk_i = ~clk_i;
  seil_event_irq u_dut (.clk_i, .sys_rst_i, .cmd_toggle_i, .cmd_code_i, .reg_wr_toggle_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .asleep_i(st[3]), .powerup_busy_i(st[2]),
    .convert_busy_i(st[1]), .cmd_busy_i(st[0]), .temp_done_i, .temp_outside_i(q[3]),
    .temp_above_i(q[2]), .temp_cross_i(q[1]), .temp_rise_i(q[0]), .press_done_i,
    .press_outside_i(q[3]), .press_above_i(q[2]), .press_cross_i(q[1]), .press_rise_i(q[0]),
    .threshold_error_flag_i, .device_ready_flag_o, .compensation_enable_o,
    .press_or_alt_select_o, .primary_irq_pin_o, .secondary_irq_pin_o);
  seil_host_model u_host (.clk_i, .ready_i(device_ready_flag_o), .rdata_i(reg_rdata_o),
    .cmd_toggle_o(cmd_toggle_i), .cmd_code_o(cmd_code_i), .wr_toggle_o(reg_wr_toggle_i),
    .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    u_host.rd(a, v);
    chk(v, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // one done pulse with its qualifiers {outside, above, cross, rise}
  task automatic ev(input logic t, input logic p, input logic [3:0] qq);
    @(negedge clk_i);
    temp_done_i = t;
    press_done_i = p;
    q = qq;
    @(negedge clk_i);
    temp_done_i = 1'b0;
    press_done_i = 1'b0;
    tick(3);
  endtask
  task automatic chk_clean();
    for (int a = 0; a < 5; a++) rdc(a[3:0], (a == 2) ? 8'h40 : 8'h00);
    rdc(4'hf, 8'h00);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end
  initial begin
    tick(5);
    sys_rst_i = 1'b0;
    u_host.wr(ADDR_EVENT_SOURCE, 8'hff);
    u_host.wr(ADDR_EVENT_DIRECTION, 8'hff);
    u_host.wr(4'hf, 8'hff);
    chk_clean();
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      st = (i < 3) ? (4'h8 | (4'h1 << i)) : 4'h0;
      tick(3);
      chk(device_ready_flag_o, 1'b0);
    end
    st = 4'h8;
    tick(3);
    chk(device_ready_flag_o, 1'b1);
    $display("test ready done");
    u_host.wr(ADDR_INT_ENABLE, 8'h3f);
    u_host.wr(ADDR_INT_ROUTE, 8'h41);
    u_host.wr(ADDR_COMPENSATION, 8'h01);
    rdc(ADDR_INT_ENABLE, 8'h3f);
    rdc(ADDR_INT_ROUTE, 8'h41);
    chk({compensation_enable_o, press_or_alt_select_o}, 2'b11);
    ev(1'b1, 1'b0, 4'b1110);
    rdc(ADDR_EVENT_SOURCE, 8'h55);
    rdc(ADDR_EVENT_DIRECTION, 8'h01);
    chk({primary_irq_pin_o, secondary_irq_pin_o}, 2'b11);
    ev(1'b0, 1'b1, 4'b1011);
    rdc(ADDR_EVENT_SOURCE, 8'h7f);
    rdc(ADDR_EVENT_DIRECTION, 8'h09);
    u_host.wr(ADDR_INT_ROUTE, 8'h40);
    chk({primary_irq_pin_o, secondary_irq_pin_o}, 2'b10);
    u_host.cmd(SEIL_CMD_CONVERT);
    chk(primary_irq_pin_o, 1'b0);
    rdc(ADDR_EVENT_SOURCE, 8'h7c);
    rdc(ADDR_EVENT_DIRECTION, 8'h09);
    threshold_error_flag_i = 1'b1;
    tick(4);
    rdc(ADDR_EVENT_SOURCE, 8'hfc);
    chk(primary_irq_pin_o, 1'b0);
    threshold_error_flag_i = 1'b0;
    $display("test events done");
    for (int i = 0; i < 8; i++) begin
      ev(1'b1, 1'b1, 4'h0);
      u_host.cmd(cds[i]);
      u_host.rd(ADDR_EVENT_SOURCE, v);
      chk(v[1:0], rem[i]);
      chk(primary_irq_pin_o, |rem[i]);
    end
    $display("test commands done");
    u_host.cmd(SEIL_CMD_SOFT_RST);
    chk_clean();
    chk({compensation_enable_o, press_or_alt_select_o, primary_irq_pin_o}, 3'b000);
    ev(1'b1, 1'b1, 4'h0);
    rdc(ADDR_EVENT_SOURCE, 8'h40);
    chk(primary_irq_pin_o, 1'b0);
    u_host.wr(ADDR_INT_ENABLE, 8'h3c);
    ev(1'b1, 1'b1, 4'hf);
    rdc(ADDR_EVENT_SOURCE, 8'h40);
    rdc(ADDR_EVENT_DIRECTION, 8'h0f);
    chk(primary_irq_pin_o, 1'b0);
    $display("test soft reset done");
    close_out();
  end
endmodule
